//--- verilog/dsdp_top.sv
// Decoder stream ports: ready flag, demand-driven serial input, serial audio output
//
// Contract
// R1: Run-enable low: ready shows crystal clock detected
// R2: Run-enable high: ready low until lock
// R3: Host ties frame id low in standard mode
// R4: Word select shows left or right channel
// R5: Strap picks format; later reconfiguration allowed
// R6: Strap selects 32-bit or 16-bit mode
// R7: Active-low reset clears all digital logic
// R8: Demand high wants data, low stops
// R9: Source starts within reaction time after rise
// R10: Source stops within 1.3 ms after fall
// R11: Recovery tracks +-200 ppm rate deviation
// R12: No new bytes while demand low
`timescale 1ns/1ps
module dsdp_top
    import dsdp_pkg::*;
(
    input  wire logic MCLK_I,
    input  wire logic RESET_N_I,
    input  wire logic CRYSTAL_CLOCK_INPUT_I,
    input  wire logic DECODER_RUN_ENABLE_I,
    input  wire logic FORMAT_STRAP_PIN_I,
    input  wire logic RECONFIG_VALID_I,
    input  wire logic RECONFIG_FORMAT_I,
    input  wire logic SERIAL_IN_CLOCK_I,
    input  wire logic SERIAL_IN_BIT_I,
    input  wire logic SERIAL_IN_FRAME_ID_I,
    output logic      DECODER_READY_FLAG_O,
    output logic      DAC_OVERSAMPLE_CLOCK_O,
    output logic      DATA_DEMAND_PIN_O,
    output logic      SERIAL_OUT_BIT_O,
    output logic      SERIAL_OUT_WORD_SELECT_O,
    output logic      SERIAL_OUT_CLOCK_O
);

    // Link domain: shift in bits on serial input clock, toggle per byte
    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] cnt;
        logic [7:0] byte_hold;
        logic       tgl;
    } dsdp_link_t;

    dsdp_link_t lnk_reg, lnk_next;

    always_comb begin
        lnk_next = lnk_reg;
        // Frame id tied low in standard mode, bits framed by clock only [R3]
        if (!SERIAL_IN_FRAME_ID_I) begin
            lnk_next.shift = {lnk_reg.shift[6:0], SERIAL_IN_BIT_I};
            lnk_next.cnt   = lnk_reg.cnt + 3'h1;
            if (lnk_reg.cnt == 3'h7) begin
                lnk_next.byte_hold = {lnk_reg.shift[6:0], SERIAL_IN_BIT_I};
                lnk_next.tgl       = ~lnk_reg.tgl;
            end
        end
    end

    always_ff @(posedge SERIAL_IN_CLOCK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin // [R7]
            lnk_reg <= '0;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    typedef enum logic [1:0] {
        ST_FILL1,
        ST_FILL2,
        ST_STRAP,
        ST_RUN
    } dsdp_state_t;

    // Core domain state
    typedef struct packed {
        dsdp_state_t state;
        logic [1:0]  xclk_sync;
        logic [1:0]  run_sync;
        logic [1:0]  strap_sync;
        logic [2:0]  tgl_sync;
        logic        xclk_last;
        logic [3:0]  xclk_edges;
        logic [7:0]  xclk_quiet;
        logic        clk_ok;
        logic [2:0]  lock_cnt;
        logic        locked;
        dsdp_fmt_t   fmt;
        logic [7:0]  level;
        logic        demand;
        logic [3:0]  ovs_cnt;
        logic        ovs;
        logic        ovs_out;
        logic [5:0]  sck_cnt;
        logic        sck;
        logic [4:0]  bit_idx;
        logic        ws;
        logic [31:0] word;
        logic [7:0]  last_byte;
        logic        sdo;
        logic        ready;
    } dsdp_core_t;

    dsdp_core_t c_reg, c_next;

    function automatic logic [4:0] last_bit(input dsdp_fmt_t f);
        last_bit = (f == DSDP_FMT_32BIT) ? 5'(WORD32_BITS - 1) : 5'(WORD16_BITS - 1);
    endfunction : last_bit

    logic byte_evt;
    logic sck_fall;
    logic word_end;

    always_comb begin
        c_next = c_reg;
        c_next.xclk_sync  = {c_reg.xclk_sync[0], CRYSTAL_CLOCK_INPUT_I};
        c_next.run_sync   = {c_reg.run_sync[0], DECODER_RUN_ENABLE_I};
        c_next.strap_sync = {c_reg.strap_sync[0], FORMAT_STRAP_PIN_I};
        c_next.tgl_sync   = {c_reg.tgl_sync[1:0], lnk_reg.tgl};
        byte_evt = c_reg.tgl_sync[2] ^ c_reg.tgl_sync[1];
        sck_fall = 1'b0;
        word_end = 1'b0;

        // Crystal clock detection: enough edges without long silence
        c_next.xclk_last = c_reg.xclk_sync[1];
        if (c_reg.xclk_sync[1] != c_reg.xclk_last) begin
            c_next.xclk_quiet = '0;
            if (c_reg.xclk_edges != 4'(XTAL_EDGES_NEEDED)) begin
                c_next.xclk_edges = c_reg.xclk_edges + 4'h1;
            end
        end else if (c_reg.xclk_quiet == 8'(XTAL_TIMEOUT_CYC - 1)) begin
            c_next.xclk_edges = '0;
        end else begin
            c_next.xclk_quiet = c_reg.xclk_quiet + 8'h01;
        end
        c_next.clk_ok = (c_reg.xclk_edges == 4'(XTAL_EDGES_NEEDED));

        case (c_reg.state)
            // Let the strap reach the end of its synchroniser first
            ST_FILL1: begin
                c_next.state = ST_FILL2;
            end
            ST_FILL2: begin
                c_next.state = ST_STRAP;
            end
            ST_STRAP: begin
                // Strap sampled once after reset release [R5] [R6]
                c_next.fmt   = c_reg.strap_sync[1] ? DSDP_FMT_32BIT : DSDP_FMT_I2S16;
                c_next.state = ST_RUN;
            end
            ST_RUN: begin
                // Later reconfiguration of the output format [R5]
                if (RECONFIG_VALID_I) begin
                    c_next.fmt = dsdp_fmt_t'(RECONFIG_FORMAT_I);
                end
            end
            default: c_next.state = ST_STRAP;
        endcase

        // Oversample clock, synchronous to the serial output
        if (c_reg.ovs_cnt == OVS_HALF - 4'h1) begin
            c_next.ovs_cnt = '0;
            c_next.ovs     = ~c_reg.ovs;
        end else begin
            c_next.ovs_cnt = c_reg.ovs_cnt + 4'h1;
        end

        // Serial output bit clock and shifting
        if (c_reg.sck_cnt == SCK_HALF - 6'h01) begin
            c_next.sck_cnt = '0;
            c_next.sck     = ~c_reg.sck;
            sck_fall       = c_reg.sck;
        end else begin
            c_next.sck_cnt = c_reg.sck_cnt + 6'h01;
        end
        if (sck_fall) begin
            c_next.sdo = c_reg.word[31];
            c_next.word = {c_reg.word[30:0], 1'b0};
            if (c_reg.bit_idx == last_bit(c_reg.fmt)) begin
                c_next.bit_idx = '0;
                c_next.ws      = ~c_reg.ws; // [R4]
                word_end       = 1'b1;
                if (c_reg.fmt == DSDP_FMT_32BIT) begin
                    c_next.word = {4{c_reg.last_byte}};
                end else begin
                    c_next.word = {{2{c_reg.last_byte}}, 16'h0000};
                end
            end else begin
                c_next.bit_idx = c_reg.bit_idx + 5'h01;
            end
        end
        // A shorter format chosen past its last bit ends the word at the next fall [R5]
        if (c_next.bit_idx > last_bit(c_next.fmt)) begin
            c_next.bit_idx = last_bit(c_next.fmt);
        end

        // Input level: bytes in, one consumed per stereo frame
        if (byte_evt) begin
            c_next.last_byte = lnk_reg.byte_hold;
        end
        if (byte_evt && !(word_end && c_reg.ws && c_reg.level != 8'h00)) begin
            if (c_reg.level != 8'hFF) begin
                c_next.level = c_reg.level + 8'h01;
            end
        end else if (!byte_evt && word_end && c_reg.ws && c_reg.level != 8'h00) begin
            c_next.level = c_reg.level - BYTES_PER_FRAME;
        end

        // Demand with hysteresis, only while running [R8]
        if (!c_reg.run_sync[1] || c_reg.level >= DEMAND_HIGH_MARK) begin
            c_next.demand = 1'b0;
        end else if (c_reg.level <= DEMAND_LOW_MARK) begin
            c_next.demand = 1'b1;
        end

        // Lock after stable stereo frames with data; rate slip absorbed by level [R11]
        if (!c_reg.run_sync[1]) begin
            c_next.lock_cnt = '0;
            c_next.locked   = 1'b0;
        end else if (word_end && c_reg.ws && c_reg.level != 8'h00) begin
            if (c_reg.lock_cnt == 3'(LOCK_WORDS)) begin
                c_next.locked = 1'b1;
            end else begin
                c_next.lock_cnt = c_reg.lock_cnt + 3'h1;
            end
        end

        // Ready meaning follows run enable [R1] [R2]
        c_next.ready = c_reg.run_sync[1] ? c_reg.locked : c_reg.clk_ok;
        // Oversample clock released only once locked [R2]
        c_next.ovs_out = c_next.ovs & c_next.locked;
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin // [R7]
            c_reg <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    assign DECODER_READY_FLAG_O     = c_reg.ready;
    assign DAC_OVERSAMPLE_CLOCK_O   = c_reg.ovs_out;
    assign DATA_DEMAND_PIN_O        = c_reg.demand;
    assign SERIAL_OUT_BIT_O         = c_reg.sdo;
    assign SERIAL_OUT_WORD_SELECT_O = c_reg.ws;
    assign SERIAL_OUT_CLOCK_O       = c_reg.sck;

    ready_run_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R2]
        c_reg.run_sync[1] && !c_reg.locked |=> !DECODER_READY_FLAG_O)
        else $error("ready high before lock");
    ready_idle_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R1]
        !c_reg.run_sync[1] |=> DECODER_READY_FLAG_O == $past(c_reg.clk_ok))
        else $error("ready not clock detect while idle");
    demand_off_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R8]
        c_reg.level >= DEMAND_HIGH_MARK |=> !DATA_DEMAND_PIN_O)
        else $error("demand high when full");
    ws_toggle_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R4]
        word_end |=> $changed(SERIAL_OUT_WORD_SELECT_O))
        else $error("word select did not toggle");
    ws_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R4]
        !word_end |=> $stable(SERIAL_OUT_WORD_SELECT_O))
        else $error("word select moved mid word");
    strap_take_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R6]
        c_reg.state == ST_STRAP |=>
            c_reg.fmt == ($past(c_reg.strap_sync[1]) ? DSDP_FMT_32BIT : DSDP_FMT_I2S16))
        else $error("strap not sampled");
    word_len_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R5]
        c_reg.bit_idx <= last_bit(c_reg.fmt) || RECONFIG_VALID_I || $past(RECONFIG_VALID_I))
        else $error("bit index beyond word");
    ovs_gate_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R2]
        !c_reg.locked |-> !DAC_OVERSAMPLE_CLOCK_O)
        else $error("oversample clock before lock");

    // Reset, demand, lock, clock detect, format and serial output checks
    reset_quiet_a: assert property (@(posedge MCLK_I) // [R7]
        !RESET_N_I |-> !DECODER_READY_FLAG_O && !DAC_OVERSAMPLE_CLOCK_O
            && !DATA_DEMAND_PIN_O && !SERIAL_OUT_CLOCK_O && !SERIAL_OUT_WORD_SELECT_O)
        else $error("outputs active in reset");
    demand_idle_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R8]
        !c_reg.run_sync[1] |=> !DATA_DEMAND_PIN_O)
        else $error("demand high while stopped");
    demand_want_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R8]
        c_reg.run_sync[1] && c_reg.level <= DEMAND_LOW_MARK |=> DATA_DEMAND_PIN_O)
        else $error("demand low when empty");
    ready_lock_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R2]
        c_reg.run_sync[1] && c_reg.locked |=> DECODER_READY_FLAG_O)
        else $error("ready low after lock");
    lock_idle_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R2]
        !c_reg.run_sync[1] |=> !c_reg.locked)
        else $error("lock held while stopped");
    clk_lost_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R1]
        c_reg.xclk_quiet == 8'(XTAL_TIMEOUT_CYC - 1) && c_reg.xclk_sync[1] == c_reg.xclk_last
            |-> ##2 !c_reg.clk_ok)
        else $error("clock detect kept after silence");
    fmt_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R5]
        c_reg.state == ST_RUN && !RECONFIG_VALID_I |=> $stable(c_reg.fmt))
        else $error("format changed without request");
    sdo_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R4]
        !sck_fall |=> $stable(SERIAL_OUT_BIT_O))
        else $error("data moved off falling clock");
    sck_rate_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // [R4]
        $changed(SERIAL_OUT_CLOCK_O) |-> $past(c_reg.sck_cnt) == SCK_HALF - 6'h01)
        else $error("bit clock half period wrong");

endmodule : dsdp_top

//--- verilog/dsdp_pkg.sv
// Package with constants and types for the decoder stream ports block
package dsdp_pkg;
    // Clock period in picoseconds (200 MHz)
    localparam int unsigned CLK_PERIOD_PS     = 5000;
    // Crystal clock detection: edges needed and silence window
    localparam int unsigned XTAL_EDGES_NEEDED = 8;
    localparam int unsigned XTAL_TIMEOUT_NS   = 1000;
    localparam int unsigned XTAL_TIMEOUT_CYC  = (XTAL_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
    // Lock: stereo frames with data counted before declaring lock
    localparam int unsigned LOCK_WORDS        = 4;
    // Tracking range in parts per million
    localparam int          TRACK_PPM_MIN     = -200;
    localparam int          TRACK_PPM_MAX     = 200;
    // Output word widths
    localparam int unsigned WORD32_BITS       = 32;
    localparam int unsigned WORD16_BITS       = 16;
    // Oversample clock divider (half period in cycles)
    localparam logic [3:0]  OVS_HALF          = 4'h2;
    // Serial output bit clock half period in cycles
    localparam logic [5:0]  SCK_HALF          = 6'h20;
    // Input bytes buffered before demand drops (high mark) and before it rises again (low mark)
    localparam logic [7:0]  DEMAND_HIGH_MARK  = 8'hC0;
    localparam logic [7:0]  DEMAND_LOW_MARK   = 8'h40;
    // Bytes consumed per output stereo frame
    localparam logic [7:0]  BYTES_PER_FRAME   = 8'h01;

    typedef enum logic [0:0] {
        DSDP_FMT_32BIT,
        DSDP_FMT_I2S16
    } dsdp_fmt_t;
endpackage : dsdp_pkg

//--- testbench/dsdp_host_model.sv
// Behavioural data source feeding the serial bitstream link
`timescale 1ns/1ps
module dsdp_host_model (
    input  wire logic       rst_n_i,
    input  wire logic       demand_i,
    input  wire logic [7:0] byte_i,
    output logic            sic_o,
    output logic            sid_o,
    output logic            sii_o
);
    logic [7:0] tx;
    initial begin
        sic_o = 1'b0;
        sid_o = 1'b0;
        sii_o = 1'b0;
    end
    // Starts promptly, finishes only the byte in flight after demand drops
    always begin
        wait (rst_n_i === 1'b1 && demand_i === 1'b1);
        #3.7;
        tx = byte_i;
        for (int i = 7; i >= 0; i--) begin
            sid_o = tx[i];
            #6 sic_o = 1'b1;
            #6 sic_o = 1'b0;
        end
        sid_o = ~sid_o;
    end
endmodule : dsdp_host_model

//--- testbench/tb_top.sv
// Self-checking bench for the decoder stream ports
`timescale 1ns/1ps
module tb_top;
    import dsdp_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n;
    logic        xtal = 1'b0;
    logic        xtal_en = 1'b1;
    logic        run_en = 1'b0;
    logic        strap = 1'b0;
    logic        sck_q = 1'b0;
    logic        sob_q = 1'b0;
    logic        ov;
    logic        rc_valid = 1'b0;
    logic        rc_fmt = 1'b0;
    logic        serial_in_clock, serial_in_bit, serial_in_frame_id;
    logic        ready, ovs, demand, sob, ws, sck;
    logic [7:0]  host_byte = 8'h00;
    logic [31:0] rng = 32'd61926;
    int          bad_count = 0;
    int          checks = 0;
    int          cyc = 0;
    int          xdiv = 0;
    int          bits;
    int          sob_moves = 0;
    always #2.5 mclk = ~mclk;
    dsdp_host_model host (.rst_n_i(rst_n), .demand_i(demand), .byte_i(host_byte),
                          .sic_o(serial_in_clock), .sid_o(serial_in_bit), .sii_o(serial_in_frame_id));
    dsdp_top dut (.MCLK_I(mclk), .RESET_N_I(rst_n), .CRYSTAL_CLOCK_INPUT_I(xtal),
        .DECODER_RUN_ENABLE_I(run_en), .FORMAT_STRAP_PIN_I(strap),
        .RECONFIG_VALID_I(rc_valid), .RECONFIG_FORMAT_I(rc_fmt),
        .SERIAL_IN_CLOCK_I(serial_in_clock), .SERIAL_IN_BIT_I(serial_in_bit), .SERIAL_IN_FRAME_ID_I(serial_in_frame_id),
        .DECODER_READY_FLAG_O(ready), .DAC_OVERSAMPLE_CLOCK_O(ovs),
        .DATA_DEMAND_PIN_O(demand), .SERIAL_OUT_BIT_O(sob),
        .SERIAL_OUT_WORD_SELECT_O(ws), .SERIAL_OUT_CLOCK_O(sck));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] s;
        s = v ^ (v << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic int exp_bits(input logic fmt);
        return (fmt == DSDP_FMT_32BIT) ? WORD32_BITS : WORD16_BITS;
    endfunction : exp_bits
    function automatic logic pick(input int sel);
        return (sel == 0) ? ready : ((sel == 1) ? demand : ws);
    endfunction : pick
    task automatic tally_and_finish;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic wait_on(input int sel, input logic lvl, input int lim);
        int n;
        n = 0;
        while (pick(sel) !== lvl && n < lim) begin
            step(1);
            n = n + 1;
        end
        chk(pick(sel), lvl);
    endtask : wait_on
    task automatic word_len(output int n);
        logic w, s;
        int k;
        w = ws;
        k = 0;
        while (ws === w && k < 10000) begin
            step(1);
            k = k + 1;
        end
        w = ws;
        s = sck;
        n = 0;
        while (ws === w && k < 20000) begin
            step(1);
            k = k + 1;
            if (sck === 1'b1 && s === 1'b0) n = n + 1;
            s = sck;
        end
    endtask : word_len
    // Random bytes for the source, crystal clock, and the hang limit
    always @(posedge mclk) begin
        #1;
        cyc = cyc + 1;
        rng = xs(rng);
        host_byte = rng[7:0];
        xdiv = (xdiv + 1) % 10;
        if (xtal_en && xdiv == 0) xtal = ~xtal;
        if (sck === 1'b1 && sck_q === 1'b1 && sob !== sob_q) sob_moves = sob_moves + 1;
        sck_q = sck;
        sob_q = sob;
        if (cyc == 100000) begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end
    initial begin
        #1;
        rst_n = 1'b0;
        step(10);
        chk({ready, ovs, demand, sob, ws, sck}, 32'h0);
        rst_n = 1'b1;
        $display("test reset done");
        wait_on(0, 1'b1, 400);
        chk(demand, 1'b0);
        xtal_en = 1'b0;
        wait_on(0, 1'b0, 800);
        xtal_en = 1'b1;
        wait_on(0, 1'b1, 400);
        run_en = 1'b1;
        step(4);
        chk(ready, 1'b0);
        chk(ovs, 1'b0);
        wait_on(1, 1'b1, 40);
        wait_on(1, 1'b0, 10000);
        wait_on(0, 1'b1, 40000);
        ov = ovs;
        step(OVS_HALF);
        chk(ovs, !ov);
        $display("test demand and lock done");
        word_len(bits);
        chk(bits, exp_bits(~strap));
        rc_fmt = 1'b0;
        rc_valid = 1'b1;
        step(1);
        rc_valid = 1'b0;
        word_len(bits);
        word_len(bits);
        chk(bits, exp_bits(rc_fmt));
        rc_fmt = 1'b1;
        rc_valid = 1'b1;
        step(1);
        rc_valid = 1'b0;
        word_len(bits);
        chk(bits, exp_bits(rc_fmt));
        $display("test output format done");
        xtal_en = 1'b0;
        run_en = 1'b0;
        wait_on(1, 1'b0, 10);
        wait_on(0, 1'b0, 400);
        chk({ovs, demand}, 32'h0);
        chk(sob_moves, 32'h0);
        $display("test run disable done");
        tally_and_finish();
    end
endmodule : tb_top
